/* File: verilog/pcr_ch1_config_regs.sv */
// Channel 1 configuration registers, shared sync period timer and lock
`timescale 1ns/10ps
`default_nettype none
module pcr_ch1_config_regs
    import pcr_pkg::*;
#(
    parameter int BASE_CYC = PCR_SYNC_BASE_CYC,
    parameter int STEP_CYC = PCR_SYNC_STEP_CYC
) (
    input  wire logic        mclk,
    input  wire logic        rst_b,
    input  wire logic        reg_wr,
    input  wire logic [5:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    output var  logic [15:0] reg_rdata,
    output var  logic        wr_refused,
    output var  logic        lockable_config_phase,
    input  wire logic        auto_sync_sel,
    input  wire logic        iface_two_sync_en,
    input  wire logic        sync_trig_one,
    input  wire logic        sync_trig_two,
    output var  logic        sync_pulse_one,
    output var  logic        sync_pulse_two,
    input  wire logic        rx_data_one,
    input  wire logic        irq_one,
    output var  logic        first_data_output_pin,
    output var  pcr_eff_t    ch1_eff
);

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [15:0] sync_period_timer_ff;
    pcr_cfg_a_t  channel_one_config_a_ff;
    logic [15:0] channel_one_config_b_ff;
    logic [15:0] channel_one_config_c_ff;
    logic [15:0] slot_tag_config_a_ff;
    logic        lockable_config_phase_phase_ff;
    logic [15:0] rdata_ff;
    logic        refused_ff;
    logic        dout_ff;
    pcr_eff_t    eff_ff;
    pcr_eff_t    nxt_eff;

    // ------------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------------
    wire hit_sync  = (reg_addr == PCR_ADDR_SYNC_PERIOD);
    wire hit_cfg_a = (reg_addr == PCR_ADDR_CFG_A);
    wire hit_cfg_b = (reg_addr == PCR_ADDR_CFG_B);
    wire hit_cfg_c = (reg_addr == PCR_ADDR_CFG_C);
    wire hit_tag   = (reg_addr == PCR_ADDR_SLOT_TAG_A);
    wire hit_cmd   = (reg_addr == PCR_ADDR_DIRECT_CMD);
    wire hit_cfg   = hit_sync || hit_cfg_a || hit_cfg_b || hit_cfg_c || hit_tag;

    wire wr_open    = reg_wr && lockable_config_phase_phase_ff;
    wire end_lockable_config_phase   = reg_wr && hit_cmd && (reg_wdata == PCR_CMD_END_LOCKABLE_CONFIG_PHASE);

    wire parity_ok  = ^reg_wdata;
    wire wr_sync    = wr_open && hit_sync;
    wire wr_cfg_a   = wr_open && hit_cfg_a && parity_ok;
    wire wr_cfg_b   = wr_open && hit_cfg_b;
    wire wr_tag     = wr_open && hit_tag;

    // ------------------------------------------------------------------
    // Propagation and refusal
    // ------------------------------------------------------------------
    // propagation condition, from the stored register
    wire prop_init   = channel_one_config_a_ff.init_data_capture;
    wire prop_simple = (channel_one_config_a_ff.slot_monitor_select == 2'b10);
    wire prop_async  = !channel_one_config_a_ff.synchronous_mode_bit;
    // Follows the stored word, not the word being written
    wire propagate   = prop_init || prop_simple || prop_async;

    wire wr_cfg_c   = wr_open && hit_cfg_c && !propagate;
    wire [15:0] keep_b_mask = propagate ? 16'h1020 | 16'h001f : PCR_MASK_CFG_B;
    wire [15:0] nxt_cfg_b   = (channel_one_config_b_ff & ~keep_b_mask)
                            | (reg_wdata & keep_b_mask);

    // Refused: locked, bad parity, or slots frozen
    wire refuse_lock   = !lockable_config_phase_phase_ff;
    wire refuse_parity = hit_cfg_a && !parity_ok;
    wire refuse_frozen = hit_cfg_c && propagate;
    // Slot 1 bits of the second word still land, so that case is not flagged
    wire refuse        = reg_wr && hit_cfg && (refuse_lock || refuse_parity || refuse_frozen);

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    // Reserved bits are masked on write, so they read back as zero
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            sync_period_timer_ff <= PCR_RST_SYNC_PERIOD;
            channel_one_config_a_ff <= pcr_cfg_a_t'(PCR_RST_CFG_A);
            channel_one_config_b_ff <= PCR_RST_CFG_B;
            channel_one_config_c_ff <= PCR_RST_CFG_C;
            slot_tag_config_a_ff <= PCR_RST_SLOT_TAG_A;
        end else begin
            if (wr_sync) begin
                sync_period_timer_ff <= reg_wdata;
            end
            if (wr_cfg_a) begin
                channel_one_config_a_ff <= pcr_cfg_a_t'(reg_wdata & PCR_MASK_CFG_A);
            end
            if (wr_cfg_b) begin
                channel_one_config_b_ff <= nxt_cfg_b;
            end
            if (wr_cfg_c) begin
                channel_one_config_c_ff <= reg_wdata & PCR_MASK_CFG_C;
            end
            if (wr_tag) begin
                slot_tag_config_a_ff <= reg_wdata & PCR_MASK_SLOT_TAG;
            end
        end
    end

    // ------------------------------------------------------------------
    // Programming phase and read path
    // ------------------------------------------------------------------
    wire [15:0] rd_mux =
        hit_sync  ? sync_period_timer_ff :
        hit_cfg_a ? 16'(channel_one_config_a_ff) :
        hit_cfg_b ? channel_one_config_b_ff :
        hit_cfg_c ? channel_one_config_c_ff :
        hit_tag   ? slot_tag_config_a_ff : 16'h0000;

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            lockable_config_phase_phase_ff <= 1'b1;
            rdata_ff      <= 16'h0000;
            refused_ff    <= 1'b0;
        end else begin
            if (end_lockable_config_phase) begin
                lockable_config_phase_phase_ff <= 1'b0;
            end
            rdata_ff   <= rd_mux;
            refused_ff <= refuse;
        end
    end

    // ------------------------------------------------------------------
    // Decode of effective settings
    // ------------------------------------------------------------------
    wire pcr_cfg_a_t ca = channel_one_config_a_ff;

    // ------------------------------------------------------------------
    // Slot width and check decode
    // ------------------------------------------------------------------
    // Slots 3 and 4 live in a word outside this block
    wire [4:0] raw_w1 = channel_one_config_b_ff[4:0];
    wire [4:0] raw_w2 = channel_one_config_b_ff[10:6];
    wire [4:0] raw_w5 = channel_one_config_c_ff[4:0];
    wire [4:0] raw_w6 = channel_one_config_c_ff[10:6];

    function automatic logic [4:0] width_of(input logic [4:0] code);
        logic ok;
        ok = (code >= PCR_WIDTH_MIN) && (code <= PCR_WIDTH_MAX);
        return ok ? code : PCR_WIDTH_DEFAULT;
    endfunction

    wire [4:0] w1 = width_of(raw_w1);
    wire [4:0] w2 = width_of(raw_w2);
    wire [4:0] w5 = width_of(raw_w5);
    wire [4:0] w6 = width_of(raw_w6);
    wire       p1 = channel_one_config_b_ff[5];
    wire       p2 = channel_one_config_b_ff[11];
    wire       p5 = channel_one_config_c_ff[5];
    wire       p6 = channel_one_config_c_ff[11];

    // ------------------------------------------------------------------
    // Effective settings
    // ------------------------------------------------------------------
    // slot count fallback
    wire slots_ok = (ca.slot_count != 3'h0) && (ca.slot_count <= PCR_SLOTS_MAX);

    wire dout_src = ca.output_pin_function ? irq_one : rx_data_one;

    always_comb begin
        nxt_eff = '0;
        nxt_eff.sync_step_high = ca.sync_voltage_select;
        nxt_eff.pin_is_irq     = ca.output_pin_function;
        nxt_eff.mon_standard   = (ca.slot_monitor_select == 2'b01);
        nxt_eff.mon_simple     = (ca.slot_monitor_select == 2'b10);
        case (ca.quiescent_limit_select)
            2'b00:   nxt_eff.qc_limit = PCR_QC_19MA;
            2'b10:   nxt_eff.qc_limit = PCR_QC_45MA;
            default: nxt_eff.qc_limit = PCR_QC_35MA;
        endcase
        nxt_eff.slots_used     = slots_ok ? ca.slot_count : PCR_SLOTS_DEFAULT;
        case (ca.baud_select)
            2'b01:   nxt_eff.baud = PCR_BAUD_189K;
            2'b10:   nxt_eff.baud = PCR_BAUD_83K;
            default: nxt_eff.baud = PCR_BAUD_125K;
        endcase
        nxt_eff.sync_mode      = ca.synchronous_mode_bit;
        nxt_eff.bootstrap_en   = !channel_one_config_b_ff[PCR_BIT_BOOTSTRAP_DIS];
        nxt_eff.init_capture   = ca.init_data_capture;
        nxt_eff.slot1_applied  = propagate;
        if (propagate) begin
            nxt_eff.slot_width  = {w1, w1, w1, w1};
            nxt_eff.slot_parity = {p1, p1, p1, p1};
        end else begin
            nxt_eff.slot_width  = {w6, w5, w2, w1};
            nxt_eff.slot_parity = {p6, p5, p2, p1};
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            eff_ff  <= '0;
            dout_ff <= 1'b0;
        end else begin
            eff_ff  <= nxt_eff;
            dout_ff <= dout_src;
        end
    end

    // ------------------------------------------------------------------
    // Sync pulse timing per interface
    // ------------------------------------------------------------------
    // Interface 2 mode lives outside this block, so its enable is a plain input
    // interface 1 uses the lower byte
    // no interface 1 sync pulses in asynchronous mode; interface 2 follows iface_two_sync_en
    pcr_sync_gate #(
        .BASE_CYC (BASE_CYC),
        .STEP_CYC (STEP_CYC)
    ) u_gate_one (
        .mclk        (mclk),
        .rst_b       (rst_b),
        .enable      (ca.synchronous_mode_bit),
        .auto_mode   (auto_sync_sel),
        .trig_req    (sync_trig_one),
        .period_code (sync_period_timer_ff[7:0]),
        .sync_pulse  (sync_pulse_one)
    );

    // interface 2 uses the upper byte
    pcr_sync_gate #(
        .BASE_CYC (BASE_CYC),
        .STEP_CYC (STEP_CYC)
    ) u_gate_two (
        .mclk        (mclk),
        .rst_b       (rst_b),
        .enable      (iface_two_sync_en),
        .auto_mode   (auto_sync_sel),
        .trig_req    (sync_trig_two),
        .period_code (sync_period_timer_ff[15:8]),
        .sync_pulse  (sync_pulse_two)
    );

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign reg_rdata             = rdata_ff;
    assign wr_refused            = refused_ff;
    assign lockable_config_phase = lockable_config_phase_phase_ff;
    assign first_data_output_pin = dout_ff;
    assign ch1_eff               = eff_ff;

endmodule // pcr_ch1_config_regs
`default_nettype wire

/* File: verilog/pcr_pkg.sv */
// Shared constants and types for the channel 1 configuration register group
`default_nettype none
package pcr_pkg;

    // ------------------------------------------------------------------
    // Register addresses (6-bit internal register index)
    // ------------------------------------------------------------------
    localparam logic [5:0] PCR_ADDR_SYNC_PERIOD = 6'h10;
    localparam logic [5:0] PCR_ADDR_CFG_A       = 6'h11;
    localparam logic [5:0] PCR_ADDR_CFG_B       = 6'h12;
    localparam logic [5:0] PCR_ADDR_CFG_C       = 6'h13;
    localparam logic [5:0] PCR_ADDR_SLOT_TAG_A  = 6'h15;
    localparam logic [5:0] PCR_ADDR_DIRECT_CMD  = 6'h1e;

    // ------------------------------------------------------------------
    // Reset values, write masks, commands
    // ------------------------------------------------------------------
    localparam logic [15:0] PCR_RST_SYNC_PERIOD = 16'h0909;
    localparam logic [15:0] PCR_RST_CFG_A       = 16'h0101;
    localparam logic [15:0] PCR_RST_CFG_B       = 16'h0514;
    localparam logic [15:0] PCR_RST_CFG_C       = 16'h0514;
    localparam logic [15:0] PCR_RST_SLOT_TAG_A  = 16'h2d49;
    localparam logic [15:0] PCR_MASK_CFG_A      = 16'hbff7;
    localparam logic [15:0] PCR_MASK_CFG_B      = 16'h1fff;
    localparam logic [15:0] PCR_MASK_CFG_C      = 16'h0fff;
    localparam logic [15:0] PCR_MASK_SLOT_TAG   = 16'h7fff;
    localparam logic [15:0] PCR_CMD_END_LOCKABLE_CONFIG_PHASE    = 16'h1111;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int PCR_BIT_BOOTSTRAP_DIS = 12;
    localparam int PCR_SLOT_HI_LSB       = 6;

    // ------------------------------------------------------------------
    // Slot data width decode
    // ------------------------------------------------------------------
    localparam logic [4:0] PCR_WIDTH_MIN     = 5'h08;
    localparam logic [4:0] PCR_WIDTH_MAX     = 5'h1c;
    localparam logic [4:0] PCR_WIDTH_DEFAULT = 5'h14;
    localparam logic [2:0] PCR_SLOTS_DEFAULT = 3'h3;
    localparam logic [2:0] PCR_SLOTS_MAX     = 3'h6;

    // ------------------------------------------------------------------
    // Sync period timing: 200 us base plus 32 us per count at 125 MHz
    // ------------------------------------------------------------------
    localparam int PCR_CLK_MHZ      = 125;
    localparam int PCR_SYNC_BASE_US = 200;
    localparam int PCR_SYNC_STEP_US = 32;
    localparam int PCR_SYNC_BASE_CYC = PCR_SYNC_BASE_US * PCR_CLK_MHZ;
    localparam int PCR_SYNC_STEP_CYC = PCR_SYNC_STEP_US * PCR_CLK_MHZ;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PCR_QC_19MA = 2'b00,
        PCR_QC_35MA = 2'b01,
        PCR_QC_45MA = 2'b10
    } pcr_qc_t;

    typedef enum logic [1:0] {
        PCR_BAUD_125K = 2'b00,
        PCR_BAUD_189K = 2'b01,
        PCR_BAUD_83K  = 2'b10
    } pcr_baud_t;

    typedef struct packed {
        logic       odd_check_bit;
        logic       rsvd_14;
        logic       sync_voltage_select;
        logic       output_pin_function;
        logic [1:0] slot_monitor_select;
        logic [1:0] quiescent_limit_select;
        logic       init_data_capture;
        logic [2:0] slot_count;
        logic       rsvd_3;
        logic [1:0] baud_select;
        logic       synchronous_mode_bit;
    } pcr_cfg_a_t;

    // Effective settings; slot index 0..3 stands for slots 1, 2, 5, 6
    typedef struct packed {
        logic            sync_step_high;
        logic            pin_is_irq;
        logic            mon_standard;
        logic            mon_simple;
        pcr_qc_t         qc_limit;
        logic [2:0]      slots_used;
        pcr_baud_t       baud;
        logic            sync_mode;
        logic            bootstrap_en;
        logic            init_capture;
        logic            slot1_applied;
        logic [3:0][4:0] slot_width;
        logic [3:0]      slot_parity;
    } pcr_eff_t;

endpackage
`default_nettype wire

/* File: verilog/pcr_sync_gate.sv */
// Sync pulse period generator and minimum spacing guard for one interface
`timescale 1ns/10ps
`default_nettype none
module pcr_sync_gate
    import pcr_pkg::*;
#(
    parameter int BASE_CYC = PCR_SYNC_BASE_CYC,
    parameter int STEP_CYC = PCR_SYNC_STEP_CYC
) (
    input  wire logic       mclk,
    input  wire logic       rst_b,
    input  wire logic       enable,
    input  wire logic       auto_mode,
    input  wire logic       trig_req,
    input  wire logic [7:0] period_code,
    output var  logic       sync_pulse
);

    logic [20:0] elapsed_ff;
    logic [20:0] nxt_elapsed;
    logic        pulse_ff;
    wire  [31:0] limit_w  = BASE_CYC + STEP_CYC * {24'h0, period_code};
    wire  [20:0] limit    = limit_w[20:0];
    wire         ripe     = (elapsed_ff >= limit);
    // Early external triggers are dropped, not deferred
    wire         fire     = enable && ripe && (auto_mode || trig_req);

    assign nxt_elapsed = fire ? 21'h0 : (ripe ? elapsed_ff : elapsed_ff + 21'h1);

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            elapsed_ff <= 21'h0;
            pulse_ff   <= 1'b0;
        end else begin
            elapsed_ff <= nxt_elapsed;
            pulse_ff   <= fire;
        end
    end

    assign sync_pulse = pulse_ff;

endmodule // pcr_sync_gate
`default_nettype wire

/* File: testbench/pcr_ch1_config_regs_chk.sv */
// Port-level property checker for the channel 1 configuration registers
`timescale 1ns/10ps
`default_nettype none
module pcr_ch1_config_regs_chk
    import pcr_pkg::*;
#(
    parameter int BASE_CYC = PCR_SYNC_BASE_CYC,
    parameter int STEP_CYC = PCR_SYNC_STEP_CYC
) (
    input wire logic        mclk,
    input wire logic        rst_b,
    input wire logic        reg_wr,
    input wire logic [5:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic        wr_refused,
    input wire logic        lockable_config_phase,
    input wire logic        auto_sync_sel,
    input wire logic        iface_two_sync_en,
    input wire logic        sync_trig_one,
    input wire logic        sync_trig_two,
    input wire logic        sync_pulse_one,
    input wire logic        sync_pulse_two,
    input wire logic        rx_data_one,
    input wire logic        irq_one,
    input wire logic        first_data_output_pin,
    input wire pcr_eff_t    ch1_eff
);
    // ----------
    // Properties
    // ----------
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    wire logic cfg_wr = reg_wr && (reg_addr inside {[6'h10:6'h13], 6'h15});
    wire logic w_ok = (ch1_eff.slot_width[0] inside {[5'h08:5'h1c]})
        && (ch1_eff.slot_width[1] inside {[5'h08:5'h1c]})
        && (ch1_eff.slot_width[2] inside {[5'h08:5'h1c]})
        && (ch1_eff.slot_width[3] inside {[5'h08:5'h1c]});

    lock_stays_low_a: assert property (
        !lockable_config_phase |=> !lockable_config_phase) else $error("lock reopened");
    lock_on_cmd_a: assert property (
        reg_wr && reg_addr == 6'h1e && reg_wdata == 16'h1111 |=> !lockable_config_phase)
        else $error("end command did not lock");
    locked_drop_a: assert property (
        cfg_wr && !lockable_config_phase |=> wr_refused) else $error("locked write taken");
    parity_drop_a: assert property (
        reg_wr && reg_addr == 6'h11 && !(^reg_wdata) |=> wr_refused)
        else $error("even parity word taken");
    gap_one_a: assert property (
        sync_pulse_one |=> !sync_pulse_one [*8]) else $error("sync pulses too close");
    gap_two_a: assert property (
        sync_pulse_two |=> !sync_pulse_two [*8]) else $error("sync pulses too close");
    async_quiet_a: assert property (
        $past(rst_b) && !ch1_eff.sync_mode && !$past(ch1_eff.sync_mode)
        && !$past(ch1_eff.sync_mode, 2) |-> !sync_pulse_one) else $error("pulse in async mode");
    prop_same_a: assert property (
        ch1_eff.slot1_applied |-> ch1_eff.slot_width[1] == ch1_eff.slot_width[0]
        && ch1_eff.slot_width[3] == ch1_eff.slot_width[0]
        && ch1_eff.slot_parity inside {4'h0, 4'hf}) else $error("slot 1 not applied");
    width_legal_a: assert property (
        $past(rst_b) |-> w_ok) else $error("slot width out of range");
    slots_legal_a: assert property (
        $past(rst_b) |-> ch1_eff.slots_used inside {[3'h1:3'h6]}) else $error("bad slot count");
    pin_route_a: assert property (
        $past(rst_b) && $stable(ch1_eff.pin_is_irq) |-> first_data_output_pin
        == (ch1_eff.pin_is_irq ? $past(irq_one) : $past(rx_data_one))) else $error("pin route");
endmodule // pcr_ch1_config_regs_chk

bind pcr_ch1_config_regs pcr_ch1_config_regs_chk #(.BASE_CYC(BASE_CYC), .STEP_CYC(STEP_CYC))
    pcr_ch1_config_regs_chk_inst (.mclk(mclk), .rst_b(rst_b), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .wr_refused(wr_refused), .lockable_config_phase(lockable_config_phase),
    .auto_sync_sel(auto_sync_sel), .iface_two_sync_en(iface_two_sync_en),
    .sync_trig_one(sync_trig_one), .sync_trig_two(sync_trig_two),
    .sync_pulse_one(sync_pulse_one), .sync_pulse_two(sync_pulse_two),
    .rx_data_one(rx_data_one), .irq_one(irq_one),
    .first_data_output_pin(first_data_output_pin), .ch1_eff(ch1_eff));
`default_nettype wire

/* File: testbench/tb_pcr_ch1_config_regs.sv */
// Directed testbench for the channel 1 configuration registers
`timescale 1ns/10ps
`default_nettype none
module tb_pcr_ch1_config_regs
    import pcr_pkg::*;
;
    localparam int BASE = 10;
    localparam int STEP = 2;
    logic        mclk;
    logic        rst_b = 1'b0;
    logic        reg_wr = 1'b0;
    logic [5:0]  reg_addr = 6'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic        auto_sync_sel = 1'b0, iface_two_sync_en = 1'b0;
    logic        sync_trig_one = 1'b0, sync_trig_two = 1'b0;
    logic        rx_data_one = 1'b0, irq_one = 1'b0;
    logic [15:0] reg_rdata;
    logic        wr_refused, lockable_config_phase, sync_pulse_one, sync_pulse_two;
    logic        first_data_output_pin, refused;
    pcr_eff_t    ch1_eff;
    int          miscompares = 0, n_compared = 0, cycles = 0;

    pcr_ch1_config_regs #(.BASE_CYC(BASE), .STEP_CYC(STEP)) pcr_ch1_config_regs_inst (
        .mclk(mclk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .wr_refused(wr_refused),
        .lockable_config_phase(lockable_config_phase), .auto_sync_sel(auto_sync_sel),
        .iface_two_sync_en(iface_two_sync_en), .sync_trig_one(sync_trig_one),
        .sync_trig_two(sync_trig_two), .sync_pulse_one(sync_pulse_one),
        .sync_pulse_two(sync_pulse_two), .rx_data_one(rx_data_one), .irq_one(irq_one),
        .first_data_output_pin(first_data_output_pin), .ch1_eff(ch1_eff));

    // ----------
    // Bench infrastructure
    // ----------
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    // Far above the few hundred cycles the scenarios need
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            final_report();
        end
    end
    task automatic final_report();
        if (miscompares == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        cmp_word({15'h0000, got}, {15'h0000, exp});
    endtask
    function automatic logic [15:0] podd(input logic [15:0] w);
        return {~^w[14:0], w[14:0]};
    endfunction
    task automatic do_reset();
        rst_b = 1'b0;
        repeat (4) @(negedge mclk);
        rst_b = 1'b1;
    endtask
    // Strobe held over one rising edge; refusal flag seen just after it
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(negedge mclk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge mclk);
        reg_wr = 1'b0;
        refused = wr_refused;
        @(negedge mclk);
    endtask
    task automatic chk_reg(input logic [5:0] a, input logic [15:0] exp);
        reg_addr = a;
        repeat (2) @(negedge mclk);
        cmp_word(reg_rdata, exp);
    endtask
    // Cycles from one pulse to the next on the chosen interface
    task automatic gap(input logic two, input int exp);
        int n;
        n = 0;
        while ((two ? sync_pulse_two : sync_pulse_one) !== 1'b1 && n < 100) begin
            @(negedge mclk);
            n++;
        end
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while ((two ? sync_pulse_two : sync_pulse_one) !== 1'b1 && n < 100);
        cmp_word(16'(n), 16'(exp));
    endtask

    // ----------
    // Scenarios
    // ----------
    task automatic t_reset_values();
        chk_reg(6'h10, 16'h0909);
        chk_reg(6'h11, 16'h0101);
        chk_reg(6'h12, 16'h0514);
        chk_reg(6'h13, 16'h0514);
        chk_reg(6'h15, 16'h2d49);
        cmp_word(16'(ch1_eff.slots_used), 16'h0003);
        cmp_bit(lockable_config_phase, 1'b1);
    endtask
    task automatic t_rw();
        wr(6'h10, 16'ha55a);
        chk_reg(6'h10, 16'ha55a);
        wr(6'h15, 16'hffff);
        chk_reg(6'h15, 16'h7fff);
        wr(6'h15, 16'h0421);
        chk_reg(6'h15, 16'h0421);
        wr(6'h11, 16'h3101);
        cmp_bit(refused, 1'b1);
        chk_reg(6'h11, 16'h0101);
        wr(6'h11, 16'hb101);
        cmp_bit(refused, 1'b0);
        wr(6'h14, 16'hffff);
        chk_reg(6'h14, 16'h0000);
    endtask
    task automatic t_decode();
        logic [2:0] c;
        for (int i = 0; i < 8; i++) begin
            c = 3'(i);
            rx_data_one = c[1];
            irq_one = ~c[1];
            wr(6'h11, podd({2'b00, c[1], c[0], c[1:0], c[1:0], c[2], c, 1'b0, c[1:0], 1'b1}));
            cmp_bit(ch1_eff.sync_step_high, c[1]);
            cmp_bit(ch1_eff.pin_is_irq, c[0]);
            cmp_bit(ch1_eff.sync_mode, 1'b1);
            cmp_bit(first_data_output_pin, c[0] ^ c[1]);
            cmp_bit(ch1_eff.mon_standard, c[1:0] == 2'd1);
            cmp_bit(ch1_eff.mon_simple, c[1:0] == 2'd2);
            cmp_word(16'(ch1_eff.qc_limit), 16'((c[1:0] == 2'd3) ? 2'd1 : c[1:0]));
            cmp_word(16'(ch1_eff.slots_used), 16'((c == 3'd0 || c == 3'd7) ? 3'd3 : c));
            cmp_word(16'(ch1_eff.baud), 16'((c[1:0] == 2'd3) ? 2'd0 : c[1:0]));
            cmp_bit(ch1_eff.init_capture, c[2]);
        end
    endtask
    task automatic t_slots();
        logic [15:0] modes [3] = '{16'h0801, 16'h0400, 16'h0481};
        wr(6'h11, podd(16'h0401));
        wr(6'h12, 16'h1f08);
        wr(6'h13, 16'h0767);
        cmp_bit(ch1_eff.slot1_applied, 1'b0);
        cmp_bit(ch1_eff.bootstrap_en, 1'b0);
        cmp_word(16'(ch1_eff.slot_width[1:0]), 16'h0388);
        cmp_word(16'(ch1_eff.slot_width[3:2]), 16'h0294);
        cmp_word(16'(ch1_eff.slot_parity), 16'h0006);
        for (int i = 0; i < 3; i++) begin
            wr(6'h11, podd(modes[i]));
            cmp_bit(ch1_eff.slot1_applied, 1'b1);
            cmp_word(16'(ch1_eff.slot_width[3]), 16'h0008);
            cmp_word(16'(ch1_eff.slot_parity), 16'h0000);
        end
        chk_reg(6'h13, 16'h0767);
        wr(6'h13, 16'h0000);
        cmp_bit(refused, 1'b1);
        chk_reg(6'h13, 16'h0767);
        wr(6'h12, 16'h0000);
        chk_reg(6'h12, 16'h0f00);
        cmp_bit(ch1_eff.bootstrap_en, 1'b1);
        cmp_word(16'(ch1_eff.slot_width[0]), 16'h0014);
    endtask
    task automatic t_sync();
        int n;
        wr(6'h10, 16'h0301);
        wr(6'h11, podd(16'h0401));
        auto_sync_sel = 1'b1;
        iface_two_sync_en = 1'b1;
        gap(1'b0, BASE + STEP * 1 + 1);
        gap(1'b1, BASE + STEP * 3 + 1);
        auto_sync_sel = 1'b0;
        sync_trig_one = 1'b1;
        sync_trig_two = 1'b1;
        gap(1'b0, BASE + STEP * 1 + 1);
        gap(1'b1, BASE + STEP * 3 + 1);
        wr(6'h11, podd(16'h0400));
        cmp_bit(ch1_eff.sync_mode, 1'b0);
        n = 0;
        repeat (40) begin
            @(negedge mclk);
            if (sync_pulse_one !== 1'b0) n++;
        end
        cmp_word(16'(n), 16'h0000);
        sync_trig_one = 1'b0;
        sync_trig_two = 1'b0;
    endtask
    task automatic t_lock();
        wr(6'h1e, 16'h1111);
        cmp_bit(lockable_config_phase, 1'b0);
        wr(6'h10, 16'h0000);
        cmp_bit(refused, 1'b1);
        chk_reg(6'h10, 16'h0301);
        do_reset();
        cmp_bit(lockable_config_phase, 1'b1);
        chk_reg(6'h10, 16'h0909);
    endtask

    initial begin
        do_reset();
        t_reset_values();
        t_rw();
        t_decode();
        t_slots();
        t_sync();
        t_lock();
        final_report();
    end
endmodule // tb_pcr_ch1_config_regs
`default_nettype wire
